//--- pkg/hbr_pkg.sv
// Functional notes
// - single read spans both strobes low; one strobe high between cycles.
// - single reads reach control registers, receive data and both status queues.
// - ordinary burst carries at most 16 word reads per strobe assertion.
// - each burst word after the first follows an a1 toggle; device presents fresh data.
// - burst ends when either strobe rises; recovery gap follows.
// - window select high ignores all address bits and returns receive data.
// - window single reads use the same cycle protocol as plain reads.
// - window bursts allow any number of word reads from receive data.
package hbr_pkg;
	localparam int addr_w = 9;
	localparam int data_w = 16;
	localparam int burst_max = 16;
	localparam int bcnt_w = 5;
	// word offsets (address bits a[9:1]) of the readable resources
	localparam logic [8:0] off_rx_data = 9'h000;
	localparam logic [8:0] off_rx_data_last = 9'h00f;
	localparam logic [8:0] off_rx_stat = 9'h020;
	localparam logic [8:0] off_tx_stat = 9'h024;
	localparam logic [8:0] off_csr_base = 9'h028;
	// identity probe word, arbitrary value
	localparam logic [15:0] probe_value = 16'h4321;
	localparam logic [15:0] reset_data = 16'h0000;
	localparam logic [4:0] reset_count = 5'h00;
	typedef enum logic [2:0] {
		hbr_src_none_t_v,
		hbr_src_rx_data,
		hbr_src_rx_stat,
		hbr_src_tx_stat,
		hbr_src_csr
	} hbr_src_t;
endpackage

//--- pkg/hbr_pop_if.sv
`timescale 1ns/1ns
interface hbr_pop_if;
	logic pop;
	hbr_pkg::hbr_src_t src;
	logic [8:0] csr_addr;
	modport dec (output pop, output src, output csr_addr);
	modport tap (input pop, input src, input csr_addr);
endinterface

//--- src/hbr_decode.sv
`timescale 1ns/1ns
module hbr_decode (
	input wire logic [8:0] addr,
	input wire logic window_sel,
	input wire logic take,
	hbr_pop_if.dec pop_bus
);
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	always_comb begin
		pop_bus.pop = take;
		pop_bus.csr_addr = addr;
		if (window_sel) begin
			pop_bus.src = hbr_pkg::hbr_src_rx_data;
		end else if (addr <= hbr_pkg::off_rx_data_last) begin
			pop_bus.src = hbr_pkg::hbr_src_rx_data;
		end else if (addr == hbr_pkg::off_rx_stat) begin
			pop_bus.src = hbr_pkg::hbr_src_rx_stat;
		end else if (addr == hbr_pkg::off_tx_stat) begin
			pop_bus.src = hbr_pkg::hbr_src_tx_stat;
		end else if (addr >= hbr_pkg::off_csr_base) begin
			pop_bus.src = hbr_pkg::hbr_src_csr;
		end else begin
			pop_bus.src = hbr_pkg::hbr_src_none_t_v;
		end
	end
endmodule

//--- src/hbr_read_port.sv
`timescale 1ns/1ns
module hbr_read_port (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic chip_select_low,
	input wire logic read_strobe_low,
	input wire logic [9:1] addr,
	input wire logic endian_sel,
	input wire logic window_sel,
	output logic [15:0] data_out,
	output logic data_oe,
	input wire logic [15:0] rx_data_word,
	input wire logic rx_data_valid,
	output logic rx_data_pop,
	input wire logic [15:0] rx_stat_word,
	output logic rx_stat_pop,
	input wire logic [15:0] tx_stat_word,
	output logic tx_stat_pop,
	output logic [8:0] csr_addr,
	output logic csr_rd,
	input wire logic [15:0] csr_word,
	output logic burst_overrun
);
	// ----------------------------------------
	// cycle framing
	// ----------------------------------------
	logic active;
	logic active_d;
	logic a1_d;
	logic window_hold;
	logic [4:0] word_count;
	logic start;
	logic step;
	logic take;
	logic [15:0] next_word;
	logic [15:0] csr_view;
	hbr_pop_if pop_bus ();

	assign active = ~chip_select_low & ~read_strobe_low;
	assign start = active & ~active_d;
	// each a1 toggle is a new word
	assign step = active & active_d & (addr[1] != a1_d);
	// words past the limit are not popped
	assign take = start | (step & (window_hold | (word_count < 5'(hbr_pkg::burst_max))));

	hbr_decode u_dec (
		.addr(addr),
		.window_sel(window_sel),
		.take(take),
		.pop_bus(pop_bus.dec)
	);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			active_d <= 1'b0;
			a1_d <= 1'b0;
		end else begin
			active_d <= active;
			a1_d <= addr[1];
		end
	end

	// window mode latched like an address
	// latched once per cycle so a late select edge cannot change the burst limit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			window_hold <= 1'b0;
		end else if (start) begin
			window_hold <= window_sel;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			word_count <= hbr_pkg::reset_count;
			burst_overrun <= 1'b0;
		end else if (start) begin
			word_count <= 5'h01;
			burst_overrun <= 1'b0;
		// a refused word leaves data_out alone, the host reads a repeat
		end else if (step) begin
			if (window_hold) begin
				word_count <= word_count;
			end else if (word_count < 5'(hbr_pkg::burst_max)) begin
				word_count <= word_count + 5'h01;
			end else begin
				burst_overrun <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// data path
	// ----------------------------------------
	always_comb begin
		unique case (pop_bus.src)
			hbr_pkg::hbr_src_rx_data: next_word = rx_data_valid ? rx_data_word : hbr_pkg::reset_data;
			hbr_pkg::hbr_src_rx_stat: next_word = rx_stat_word;
			hbr_pkg::hbr_src_tx_stat: next_word = tx_stat_word;
			hbr_pkg::hbr_src_csr: next_word = csr_word;
			default: next_word = hbr_pkg::probe_value;
		endcase
		// byte swap applies a big endian view
		if (endian_sel) begin
			next_word = {next_word[7:0], next_word[15:8]};
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			data_out <= hbr_pkg::reset_data;
			rx_data_pop <= 1'b0;
			rx_stat_pop <= 1'b0;
			tx_stat_pop <= 1'b0;
			csr_rd <= 1'b0;
			csr_addr <= 9'h000;
		end else begin
			if (pop_bus.pop && (pop_bus.src != hbr_pkg::hbr_src_csr)) begin
				data_out <= next_word;
			// csr word lands one edge after its request
			end else if (csr_rd) begin
				data_out <= csr_view;
			end
			rx_data_pop <= pop_bus.pop & (pop_bus.src == hbr_pkg::hbr_src_rx_data) & rx_data_valid;
			rx_stat_pop <= pop_bus.pop & (pop_bus.src == hbr_pkg::hbr_src_rx_stat);
			tx_stat_pop <= pop_bus.pop & (pop_bus.src == hbr_pkg::hbr_src_tx_stat);
			csr_rd <= pop_bus.pop & (pop_bus.src == hbr_pkg::hbr_src_csr);
			csr_addr <= pop_bus.csr_addr;
		end
	end

	assign data_oe = active & active_d;

	// the csr file answers the registered address, a cycle behind the strobe
	assign csr_view = endian_sel ? {csr_word[7:0], csr_word[15:8]} : csr_word;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// pin level sequences keep the checks apart from the framing logic
	sequence s_both_low;
		!chip_select_low && !read_strobe_low;
	endsequence

	sequence s_cycle_open;
		(chip_select_low || read_strobe_low) ##1 s_both_low;
	endsequence

	sequence s_toggle_step;
		s_both_low ##1 (!chip_select_low && !read_strobe_low && $changed(addr[1]));
	endsequence

	a_oe_follows_strobes: assert property (@(posedge mclk) disable iff (sys_rst)
		data_oe |-> (!chip_select_low && !read_strobe_low && $past(active)))
		else $error("bus driven outside cycle");

	a_oe_opens: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_cycle_open ##1 s_both_low) |-> data_oe)
		else $error("bus not driven inside cycle");

	a_oe_closes: assert property (@(posedge mclk) disable iff (sys_rst)
		(chip_select_low || read_strobe_low) |-> !data_oe)
		else $error("bus driven with a strobe high");

	a_burst_limit: assert property (@(posedge mclk) disable iff (sys_rst)
		(!window_hold && word_count == 5'(hbr_pkg::burst_max) && step) |=> !rx_data_pop) else $error("pop past burst limit");

	a_burst_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_toggle_step ##0 (!window_hold && word_count < 5'(hbr_pkg::burst_max) && rx_data_valid))
		|=> rx_data_pop) else $error("burst word inside limit not popped");

	a_overrun_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
		(burst_overrun && !start) |=> burst_overrun)
		else $error("overrun flag dropped inside cycle");

	a_window_decode: assert property (@(posedge mclk) disable iff (sys_rst)
		(take && window_sel && rx_data_valid) |=> rx_data_pop) else $error("window read missed queue");

	a_window_upper: assert property (@(posedge mclk) disable iff (sys_rst)
		(start && window_sel && rx_data_valid)
		|=> (rx_data_pop && !csr_rd && !rx_stat_pop && !tx_stat_pop))
		else $error("window read decoded upper address");

	a_toggle_fresh: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_toggle_step ##0 (window_hold && rx_data_valid)) |=> rx_data_pop)
		else $error("toggle gave no word");

	a_data_holds: assert property (@(posedge mclk) disable iff (sys_rst)
		(!pop_bus.pop && !csr_rd) |=> $stable(data_out))
		else $error("read word changed without a take");

	a_start_takes: assert property (@(posedge mclk) disable iff (sys_rst)
		(start && !window_sel && addr == hbr_pkg::off_rx_stat) |=> rx_stat_pop)
		else $error("cycle start not taken");

	a_tx_pop: assert property (@(posedge mclk) disable iff (sys_rst)
		(start && !window_sel && addr == hbr_pkg::off_tx_stat) |=> tx_stat_pop)
		else $error("tx status read not popped");

	a_single_pop: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_both_low ##1 (!chip_select_low && !read_strobe_low && $stable(addr)))
		|=> !(rx_data_pop || rx_stat_pop || tx_stat_pop || csr_rd))
		else $error("double status pop");

	a_empty_no_pop: assert property (@(posedge mclk) disable iff (sys_rst)
		!rx_data_valid |=> !rx_data_pop)
		else $error("empty queue popped");

	a_csr_request: assert property (@(posedge mclk) disable iff (sys_rst)
		(start && !window_sel && addr >= hbr_pkg::off_csr_base)
		|=> (csr_rd && csr_addr == $past(addr))) else $error("csr request lost");

	a_csr_answer: assert property (@(posedge mclk) disable iff (sys_rst)
		(csr_rd && !pop_bus.pop && !endian_sel) |=> data_out == $past(csr_word))
		else $error("csr word not returned");

	a_window_unbounded: assert property (@(posedge mclk) disable iff (sys_rst)
		window_hold |-> !burst_overrun) else $error("window burst limited");

	a_burst_restart: assert property (@(posedge mclk) disable iff (sys_rst)
		start |=> word_count == 5'd1) else $error("burst count not restarted");
endmodule

//--- dv/hbr_queue_model.sv
`timescale 1ns/1ns
module hbr_queue_model (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic rx_data_pop,
	output logic [15:0] rx_data_word,
	output logic rx_data_valid,
	input wire logic rx_stat_pop,
	output logic [15:0] rx_stat_word,
	input wire logic tx_stat_pop,
	output logic [15:0] tx_stat_word,
	input wire logic [8:0] csr_addr,
	input wire logic csr_rd,
	input wire logic rx_empty,
	output logic [15:0] csr_word
);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_data_word <= 16'h1000;
			rx_stat_word <= 16'h5a00;
			tx_stat_word <= 16'ha500;
		end else begin
			rx_data_word <= rx_data_word + {15'h0, rx_data_pop};
			rx_stat_word <= rx_stat_word + {15'h0, rx_stat_pop};
			tx_stat_word <= tx_stat_word + {15'h0, tx_stat_pop};
		end
	end
	// the bench can empty the queue to see a read refused
	assign rx_data_valid = ~rx_empty;
	// the word stands only with the request, so csr_rd is judged too
	assign csr_word = csr_rd ? {7'h0, csr_addr} : 16'hffff;
endmodule

//--- dv/test_host_bus_read_cycles.sv
`timescale 1ns/1ns
module test_host_bus_read_cycles;
	logic mclk = 0, sys_rst = 1, chip_select_low = 1, read_strobe_low = 1;
	logic [9:1] addr = 9'h000;
	logic endian_sel = 0, window_sel = 0, data_oe, rx_data_valid, rx_data_pop;
	logic rx_stat_pop, tx_stat_pop, csr_rd, burst_overrun;
	logic rx_empty = 0;
	logic [15:0] data_out, rx_data_word, rx_stat_word, tx_stat_word, csr_word;
	logic [15:0] exp_rx = 16'h1000;
	logic [8:0] csr_addr;
	int err_count = 0, n_tests = 0, cyc = 0;
	hbr_read_port hbr_read_port_i (.mclk, .sys_rst, .chip_select_low, .read_strobe_low,
		.addr, .endian_sel, .window_sel, .data_out, .data_oe, .rx_data_word,
		.rx_data_valid, .rx_data_pop, .rx_stat_word, .rx_stat_pop, .tx_stat_word,
		.tx_stat_pop, .csr_addr, .csr_rd, .csr_word, .burst_overrun);
	hbr_queue_model hbr_queue_model_i (.mclk, .sys_rst, .rx_data_pop, .rx_data_word,
		.rx_data_valid, .rx_stat_pop, .rx_stat_word, .tx_stat_pop, .tx_stat_word,
		.csr_addr, .csr_rd, .rx_empty, .csr_word);
	always #5 mclk = ~mclk;
	// ----------------
	// helpers
	// ----------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic go(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic rd1(input logic [9:1] a, input logic es, input logic ws,
		input logic [15:0] exp, input string what);
		addr = a;
		endian_sel = es;
		window_sel = ws;
		chip_select_low = 0;
		read_strobe_low = 0;
		go(3);
		chk(data_out, exp, what);
		chk({15'h0, data_oe}, 16'h0001, "oe on");
		chip_select_low = 1;
		read_strobe_low = 1;
		// recovery is plain idle time, no dummy probe reads
		go(2);
		chk({15'h0, data_oe}, 16'h0000, "oe off");
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_single;
		// no level, discard or command register is read here
		rd1(9'h010, 0, 0, 16'h4321, "probe");
		rd1(9'h010, 1, 0, 16'h2143, "swap");
		rd1(9'h020, 0, 0, 16'h5a00, "rx stat");
		rd1(9'h020, 0, 0, 16'h5a01, "rx stat 2");
		rd1(9'h024, 0, 0, 16'ha500, "tx stat");
		rd1(9'h024, 0, 0, 16'ha501, "tx stat 2");
		rd1(9'h030, 0, 0, 16'h0030, "csr");
		rd1(9'h12c, 1, 0, 16'h2c01, "csr swap");
		rd1(9'h000, 0, 0, exp_rx, "rx data");
		exp_rx++;
		rd1(9'h1fc, 0, 1, exp_rx, "window");
		exp_rx++;
		rx_empty = 1;
		rd1(9'h001, 0, 0, 16'h0000, "empty");
		rx_empty = 0;
	endtask
	// ordinary burst runs one word past the limit to see the refusal
	task automatic t_burst(input logic ws, input int n);
		// bursts aim only at receive data
		addr = ws ? 9'h1f8 : 9'h000;
		window_sel = ws;
		chip_select_low = 0;
		read_strobe_low = 0;
		for (int i = 0; i < n; i++) begin
			if (i > 0) addr[1] = ~addr[1];
			go(3);
			chk(data_out, (ws || i < 16) ? exp_rx : exp_rx - 16'h1, "burst word");
			if (ws || i < 16) exp_rx++;
			chk({15'h0, burst_overrun}, {15'h0, !ws && i >= 16}, "overrun");
		end
		chip_select_low = 1;
		go(2);
		chk({15'h0, data_oe}, 16'h0000, "burst end");
		read_strobe_low = 1;
		go(2);
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 1000) begin
			err_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		sys_rst = 0;
		go(1);
		t_single;
		t_burst(0, 17);
		t_burst(1, 20);
		print_verdict;
	end
endmodule
